// ---- testbench/spcm_host_model.sv ----
// behavioural spi host that drives the client pins from outside
`default_nettype none
module spcm_host_model (
	output logic sck, // serial clock, idle low
	output logic ss_n, // client select, active low
	output logic mosi, // host data out
	input wire logic miso // resolved client data line
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF_NS = 200; // half of the 400 ns link period
	// idle levels, clock stands still between frames
	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// select level alone, for role and drive checks
	task automatic set_ss(input logic v);
		#5; // keep pin changes off the system clock edge
		ss_n = v;
		#HALF_NS;
	endtask
	// mode 0 frame of nbits, msb first; sel high frames it
	task automatic xfer(input logic [7:0] tx, input int nbits, input logic sel,
		output logic [7:0] rx);
		#5; // every later pin edge lands between system clock edges
		rx = 8'h00;
		ss_n = ~sel;
		for (int i = 7; i > 7 - nbits; i--) begin
			mosi = tx[i];
			#HALF_NS;
			sck = 1'b1;
			rx[i] = miso;
			#HALF_NS;
			sck = 1'b0;
		end
		#HALF_NS;
		ss_n = 1'b1;
		mosi = ~mosi; // released line must not keep its last value
		#HALF_NS;
	endtask
endmodule
`default_nettype wire

// ---- testbench/spcm_top_tb.sv ----
// self-checking bench for the spi client and multi-host select block
`default_nettype none
module spcm_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spcm_pkg::*;
	logic clk_sys, resetn, reg_wr, reg_rd, sck, ss_n, mosi, miso_out, miso_oe, miso_w;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rx, mo, tx, last_rx;
	logic [7:0] ctl_t [3] = '{8'h81, 8'h83, 8'h81};
	logic [7:0] pin_t [3] = '{8'h00, 8'h00, 8'h01};
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	integer seed = 32'h98137681;
	// pull-up on the client out line when nobody drives it
	assign miso_w = miso_oe ? miso_out : 1'b1;
	spcm_top u_spcm_top (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso_out), .miso_oe(miso_oe));
	spcm_host_model u_spcm_host_model (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_w));
	always #25 clk_sys = ~clk_sys;
	// hang guard, far above the roughly one thousand cycles needed
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction
	// one full frame with random host data; model keeps the received byte
	task automatic frame(input logic [7:0] exp_miso, input logic ord);
		mo = 8'($random(seed));
		u_spcm_host_model.xfer(mo, 8, 1'b1, rx);
		chk("miso byte", rx, exp_miso);
		last_rx = ord ? rev(mo) : mo;
		repeat (8) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		resetn = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		rd_chk("ctrl reset", SPCM_A_CTRL, 8'h00);
		rd_chk("flags reset", SPCM_A_FLAGS, SPCM_FLAGS_RST);
		wr(3'h5, 8'hFF);
		rd_chk("unmapped", 3'h5, 8'h00);
		// unbuffered client: pulses while deselected do nothing
		wr(SPCM_A_PIN, 8'h02);
		wr(SPCM_A_CTRL, 8'h80);
		wr(SPCM_A_DATA, 8'hA5);
		u_spcm_host_model.xfer(8'hFF, 8, 1'b0, rx);
		rd_chk("idle flags", SPCM_A_FLAGS, 8'h04);
		frame(8'hA5, 1'b0);
		rd_chk("done flag", SPCM_A_FLAGS, 8'h05);
		rd_chk("rx data", SPCM_A_DATA, last_rx);
		// write in mid-transfer is dropped
		wr(SPCM_A_FLAGS, 8'h1F);
		wr(SPCM_A_DATA, 8'h3C);
		fork
			frame(8'h3C, 1'b0);
			begin
				repeat (40) @(posedge clk_sys);
				wr(SPCM_A_DATA, 8'hC3);
			end
		join
		rd_chk("collision", SPCM_A_FLAGS, 8'h07);
		// select rise mid-byte discards it
		wr(SPCM_A_FLAGS, 8'h1F);
		u_spcm_host_model.xfer(8'h0F, 4, 1'b1, rx);
		rd_chk("abort flags", SPCM_A_FLAGS, 8'h04);
		wr(SPCM_A_DATA, 8'h5A);
		frame(8'h5A, 1'b0);
		rd_chk("rx after abort", SPCM_A_DATA, last_rx);
		// buffered, dummy first byte, full buffer refuses
		wr(SPCM_A_CTRL, 8'h84);
		wr(SPCM_A_FLAGS, 8'h1F);
		wr(SPCM_A_DATA, 8'h43);
		rd_chk("dre low", SPCM_A_FLAGS, 8'h00);
		wr(SPCM_A_DATA, 8'h45);
		frame(last_rx, 1'b0);
		rd_chk("after dummy", SPCM_A_FLAGS, 8'h0C);
		wr(SPCM_A_FLAGS, 8'h1F);
		frame(8'h43, 1'b0);
		rd_chk("drained", SPCM_A_FLAGS, 8'h1C);
		// buffered, prefilled while deselected
		wr(SPCM_A_CTRL, 8'h8C);
		wr(SPCM_A_DATA, 8'h46);
		rd_chk("prefill dre", SPCM_A_FLAGS, 8'h1C);
		wr(SPCM_A_DATA, 8'h47);
		frame(8'h46, 1'b0);
		frame(8'h47, 1'b0);
		// lsb first, random byte
		wr(SPCM_A_CTRL, 8'h90);
		tx = 8'($random(seed));
		wr(SPCM_A_DATA, tx);
		frame(rev(tx), 1'b1);
		rd_chk("rx lsb", SPCM_A_DATA, last_rx);
		// miso drive follows select and direction
		u_spcm_host_model.set_ss(1'b0);
		repeat (8) @(posedge clk_sys);
		#1;
		chk("oe selected", {7'h00, miso_oe}, 8'h01);
		wr(SPCM_A_PIN, 8'h00);
		#1; // let the pin register settle after the write edge
		chk("oe input", {7'h00, miso_oe}, 8'h00);
		u_spcm_host_model.set_ss(1'b1);
		wr(SPCM_A_PIN, 8'h02);
		repeat (8) @(posedge clk_sys);
		#1;
		chk("oe deselected", {7'h00, miso_oe}, 8'h00);
		// host role against a low select, three control and pin setups
		for (int k = 0; k < 3; k++) begin
			wr(SPCM_A_PIN, pin_t[k]);
			wr(SPCM_A_FLAGS, 8'h1F);
			wr(SPCM_A_CTRL, ctl_t[k]);
			u_spcm_host_model.set_ss(1'b0);
			repeat (8) @(posedge clk_sys);
			rd_chk("host role", SPCM_A_CTRL, ctl_t[k] & ~{7'h00, k == 0});
			rd_chk("role flag", SPCM_A_FLAGS, {7'h02, k == 0});
			u_spcm_host_model.set_ss(1'b1);
		end
		wr(SPCM_A_CTRL, 8'h81);
		rd_chk("role back", SPCM_A_CTRL, 8'h81);
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- verilog/spcm_pkg.sv ----
// constants and types shared by the spi client and multi-host select block
`default_nettype none
package spcm_pkg;
	localparam int SPCM_DATA_W = 8;
	localparam int SPCM_CNT_W = 3;
	localparam logic [SPCM_DATA_W-1:0] SPCM_DATA_RST = 8'h00;
	localparam logic [SPCM_CNT_W-1:0] SPCM_CNT_LAST = 3'h7;
	localparam logic [SPCM_CNT_W-1:0] SPCM_CNT_RST = 3'h0;
	localparam logic [1:0] SPCM_SYNC_RST = 2'h3;
	// register offsets
	localparam logic [2:0] SPCM_A_CTRL = 3'h0;
	localparam logic [2:0] SPCM_A_FLAGS = 3'h1;
	localparam logic [2:0] SPCM_A_DATA = 3'h2;
	localparam logic [2:0] SPCM_A_PIN = 3'h3;
	// control register fields
	localparam int SPCM_C_HOST = 0;
	localparam int SPCM_C_IGN = 1;
	localparam int SPCM_C_BUF = 2;
	localparam int SPCM_C_PRE = 3;
	localparam int SPCM_C_ORD = 4;
	localparam int SPCM_C_CPHA = 5;
	localparam int SPCM_C_CPOL = 6;
	localparam int SPCM_C_EN = 7;
	// flag register fields, write one to clear except the read-only empty flag
	localparam int SPCM_F_DONE = 0;
	localparam int SPCM_F_COL = 1;
	localparam int SPCM_F_DRE = 2;
	localparam int SPCM_F_RXC = 3;
	localparam int SPCM_F_TXC = 4;
	// pin register fields
	localparam int SPCM_P_SSOUT = 0;
	localparam int SPCM_P_MISOOUT = 1;
	localparam logic [7:0] SPCM_FLAGS_RST = 8'h04;
	typedef enum logic [1:0] {
		SPCM_IDLE = 2'b00,
		SPCM_SHIFT = 2'b01,
		SPCM_HOLD = 2'b10
	} spcm_state_t;
endpackage
`default_nettype wire

// ---- verilog/spcm_sync.sv ----
// two-flop synchroniser with edge outputs taken from the second and third stages
`default_nettype none
module spcm_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic d_in, // asynchronous pin
	output logic q_out, // synchronised level
	output logic rise, // one-cycle rising edge
	output logic fall // one-cycle falling edge
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// s1 feeds s2 only; edges compare s2 and s3
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign q_out = s2_q;
	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ---- verilog/spcm_top.sv ----
// spi client with buffered modes and multi-host select handling
//
// The implementer's own choices: the register addresses and strobed register access.
`default_nettype none
module spcm_top (
	input wire logic clk_sys, // 20 MHz system clock
	input wire logic resetn, // async reset, active low
	input wire logic [2:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic sck_in, // serial clock pin
	input wire logic ss_n_in, // client select pin, active low
	input wire logic mosi_in, // host out client in
	output logic miso_out, // client out level
	output logic miso_oe // miso drive enable
);
	import spcm_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] pin_q;
	logic done_q, col_q, dre_q, rxc_q, txc_q;
	logic [SPCM_DATA_W-1:0] shift_q, txbuf_q, rxdata_q;
	logic [SPCM_CNT_W-1:0] cnt_q;
	spcm_state_t state_q;
	logic pre_pend_q, dre_rise_q, rxc_rise_q, byte_end_q;
	logic empty_end_q, filled_q;
	logic miso_q;
	logic [7:0] rdata_q;
	logic sck_s, sck_r, sck_f, ss_s, ss_r, ss_f, mosi_s;

	// pins are asynchronous, all pass two flops
	// sck resets to its idle-low level, else a false edge follows reset
	spcm_sync #(.RST_VAL(1'b0)) u_sck (.clk_sys(clk_sys), .resetn(resetn), .d_in(sck_in),
		.q_out(sck_s), .rise(sck_r), .fall(sck_f));
	spcm_sync #(.RST_VAL(1'b1)) u_ss (.clk_sys(clk_sys), .resetn(resetn), .d_in(ss_n_in),
		.q_out(ss_s), .rise(ss_r), .fall(ss_f));
	spcm_sync #(.RST_VAL(1'b0)) u_mosi (.clk_sys(clk_sys), .resetn(resetn), .d_in(mosi_in),
		.q_out(mosi_s), .rise(), .fall());

	logic en, host, ign, bufm, pre, lsbf, cpha, cpol, ss_is_out;
	assign en = ctrl_q[SPCM_C_EN];
	assign host = ctrl_q[SPCM_C_HOST];
	assign ign = ctrl_q[SPCM_C_IGN];
	assign bufm = ctrl_q[SPCM_C_BUF];
	assign pre = ctrl_q[SPCM_C_PRE];
	assign lsbf = ctrl_q[SPCM_C_ORD];
	assign cpha = ctrl_q[SPCM_C_CPHA];
	assign cpol = ctrl_q[SPCM_C_CPOL];
	assign ss_is_out = pin_q[SPCM_P_SSOUT];

	logic client, selected, wr_data, wr_ctrl, wr_flags;
	// client mode ignores port direction of ss, mosi, sck
	assign client = en & ~host;
	assign selected = client & ~ss_s;
	assign wr_data = reg_wr & (reg_addr == SPCM_A_DATA);
	assign wr_ctrl = reg_wr & (reg_addr == SPCM_A_CTRL);
	assign wr_flags = reg_wr & (reg_addr == SPCM_A_FLAGS);

	// host yields only if select is an honoured input and low
	logic host_lost;
	assign host_lost = en & host & ~ign & ~ss_is_out & ~ss_s;

	// leading edge is rise when idle-low, fall when idle-high
	logic lead, trail, sample, launch;
	assign lead = cpol ? sck_f : sck_r;
	assign trail = cpol ? sck_r : sck_f;
	assign sample = cpha ? trail : lead;
	assign launch = cpha ? lead : trail;

	logic busy, last_bit, byte_done;
	assign busy = (state_q != SPCM_IDLE);
	assign last_bit = (cnt_q == SPCM_CNT_LAST);
	assign byte_done = selected & sample & last_bit & ~ss_r;

	// next outgoing bit per bit order
	function automatic logic out_bit(input logic [SPCM_DATA_W-1:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[SPCM_DATA_W-1];
	endfunction

	function automatic logic [SPCM_DATA_W-1:0] shift_in(input logic [SPCM_DATA_W-1:0] v,
		input logic lsb, input logic b);
		shift_in = lsb ? {b, v[SPCM_DATA_W-1:1]} : {v[SPCM_DATA_W-2:0], b};
	endfunction

	// unbuffered writes that hit a running transfer collide
	logic col_hit, buf_wr_ok;
	assign col_hit = wr_data & client & ~bufm & busy;
	assign buf_wr_ok = wr_data & bufm & dre_q & ~(pre_pend_q);

	// control and pin direction registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= '0;
			pin_q <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata;
			end else if (host_lost) begin
				ctrl_q[SPCM_C_HOST] <= 1'b0;
			end
			if (reg_wr & (reg_addr == SPCM_A_PIN)) begin
				pin_q <= reg_wdata;
			end
		end
	end

	// client sequencer; deselect resets state and bit count mid-byte
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= SPCM_IDLE;
			cnt_q <= SPCM_CNT_RST;
		end else if (!selected || ss_r) begin
			state_q <= SPCM_IDLE;
			cnt_q <= SPCM_CNT_RST;
		end else if (sample) begin
			if (last_bit) begin
				state_q <= SPCM_HOLD;
				cnt_q <= SPCM_CNT_RST;
			end else begin
				state_q <= SPCM_SHIFT;
				cnt_q <= cnt_q + 3'h1;
			end
		end else if (state_q == SPCM_HOLD && launch) begin
			state_q <= SPCM_IDLE;
		end
	end

	// shift register, transmit buffer and receive data
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift_q <= SPCM_DATA_RST;
			txbuf_q <= SPCM_DATA_RST;
			rxdata_q <= SPCM_DATA_RST;
			pre_pend_q <= 1'b0;
		end else begin
			pre_pend_q <= 1'b0;
			if (byte_done) begin
				rxdata_q <= shift_in(shift_q, lsbf, mosi_s);
				if (bufm && !dre_q) begin
					shift_q <= txbuf_q;
				end else begin
					shift_q <= shift_in(shift_q, lsbf, mosi_s);
				end
			end else if (selected && sample) begin
				shift_q <= shift_in(shift_q, lsbf, mosi_s);
			end else if (pre_pend_q) begin
				shift_q <= txbuf_q;
			end else if (wr_data && !bufm && !col_hit) begin
				shift_q <= reg_wdata;
			end
			if (buf_wr_ok) begin
				txbuf_q <= reg_wdata;
				pre_pend_q <= pre & ss_s & client & ~busy & ~filled_q;
			end
		end
	end

	// flag set wins over software clear
	logic dre_set;
	assign dre_set = (byte_done & bufm & ~dre_q) | pre_pend_q;

	// byte-end pipeline that spaces the buffered flags one cycle apart
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dre_rise_q <= 1'b0;
			rxc_rise_q <= 1'b0;
			byte_end_q <= 1'b0;
		end else begin
			byte_end_q <= byte_done & bufm;
			dre_rise_q <= dre_set | (byte_done & bufm & dre_q);
			rxc_rise_q <= dre_rise_q & ~pre_pend_q & byte_end_q;
		end
	end

	// byte ended with nothing to reload: shifter and buffer both sent
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			empty_end_q <= 1'b0;
		end else if (byte_done) begin
			empty_end_q <= bufm & dre_q;
		end
	end

	// prefill taken once per drained shifter, later writes stay buffered
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			filled_q <= 1'b0;
		end else if (!bufm || (byte_done && dre_q)) begin
			filled_q <= 1'b0;
		end else if (pre_pend_q) begin
			filled_q <= 1'b1;
		end
	end

	// transfer-done, unbuffered bytes and lost host role
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else if ((byte_done & ~bufm) | host_lost) begin
			done_q <= 1'b1;
		end else if (wr_flags && reg_wdata[SPCM_F_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// write collision
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			col_q <= 1'b0;
		end else if (col_hit) begin
			col_q <= 1'b1;
		end else if (wr_flags && reg_wdata[SPCM_F_COL]) begin
			col_q <= 1'b0;
		end
	end

	// buffer empty, read only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dre_q <= SPCM_FLAGS_RST[SPCM_F_DRE];
		end else if (dre_set) begin
			dre_q <= 1'b1;
		end else if (buf_wr_ok) begin
			dre_q <= 1'b0;
		end
	end

	// receive complete, one cycle behind the empty flag
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rxc_q <= 1'b0;
		end else if (dre_rise_q && byte_end_q) begin
			rxc_q <= 1'b1;
		end else if (wr_flags && reg_wdata[SPCM_F_RXC]) begin
			rxc_q <= 1'b0;
		end
	end

	// transfer complete; the hold state after the last bit must not block it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			txc_q <= 1'b0;
		end else if (rxc_rise_q && dre_q && empty_end_q) begin
			txc_q <= 1'b1;
		end else if (wr_flags && reg_wdata[SPCM_F_TXC]) begin
			txc_q <= 1'b0;
		end
	end

	// miso launches first bit at select, then on launch edges
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			miso_q <= 1'b0;
		end else if (!selected || ss_f || (launch && state_q != SPCM_IDLE) || pre_pend_q) begin
			miso_q <= out_bit(shift_q, lsbf);
		end
	end
	assign miso_out = miso_q;
	assign miso_oe = selected & pin_q[SPCM_P_MISOOUT];

	// read mux, data one cycle after strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				SPCM_A_CTRL: rdata_q <= ctrl_q;
				SPCM_A_FLAGS: rdata_q <= {3'h0, txc_q, rxc_q, dre_q, col_q, done_q};
				SPCM_A_DATA: rdata_q <= rxdata_q;
				SPCM_A_PIN: rdata_q <= pin_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	a_host_loss: assert property (@(posedge clk_sys) disable iff (!resetn)
		host_lost && !wr_ctrl |=> !host && done_q) else $error("host role not lost");
	a_ignore_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
		en && host && (ign || ss_is_out) && !wr_ctrl |=> host) else $error("host dropped");
	a_outpin_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
		en && host && !ign && ss_is_out && !ss_s && !wr_ctrl |=> host)
		else $error("output select acted");
	a_idle_desel: assert property (@(posedge clk_sys) disable iff (!resetn)
		ss_s |=> state_q == SPCM_IDLE && cnt_q == SPCM_CNT_RST) else $error("not idle");
	a_col_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
		col_hit && !(selected && sample) |=> col_q && $stable(shift_q)) else $error("col");
	a_full_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
		wr_data && bufm && !dre_q |=> $stable(txbuf_q)) else $error("full buffer written");
	a_dre_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		buf_wr_ok && !dre_set |=> !dre_q) else $error("empty flag kept");
	a_rxc_after: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(rxc_q) |-> $past(dre_rise_q)) else $error("rxc timing");
	a_miso_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
		miso_oe |-> !ss_s && pin_q[SPCM_P_MISOOUT]) else $error("miso drive");
	a_done_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		byte_done && !bufm |=> done_q) else $error("done flag missing");
	a_dummy_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		byte_done && bufm && !dre_q |=> shift_q == $past(txbuf_q) && dre_q)
		else $error("buffer not moved");
	a_prefill_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
		pre_pend_q && !selected |=> shift_q == $past(txbuf_q) && dre_q)
		else $error("prefill not copied");
	a_txc_after: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(txc_q) |-> $past(rxc_q)) else $error("txc timing");
	c_byte: cover property (@(posedge clk_sys) disable iff (!resetn) byte_done);
	c_col: cover property (@(posedge clk_sys) disable iff (!resetn) col_hit);
	c_lost: cover property (@(posedge clk_sys) disable iff (!resetn) host_lost);
	c_rxc: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(rxc_q));
	c_prefill: cover property (@(posedge clk_sys) disable iff (!resetn) pre_pend_q);
endmodule
`default_nettype wire
